// ### pkg/ssx_cfg.svh
// timing, field and address constants for the shelf expander controller
`ifndef SSX_CFG_SVH
`define SSX_CFG_SVH

// -------------------------------------------------------------------------
// register offsets of the controller (byte addresses)
// -------------------------------------------------------------------------
`define SSX_OFS_CTRL     8'h00
`define SSX_OFS_OUTBYTE  8'h04
`define SSX_OFS_POT      8'h08
`define SSX_OFS_STATUS   8'h0C
`define SSX_OFS_FLAGS    8'h10

// -------------------------------------------------------------------------
// control register fields
// -------------------------------------------------------------------------
`define SSX_CTRL_AUX1    0
`define SSX_CTRL_TXREQ   1
`define SSX_CTRL_SQDIG   2
`define SSX_CTRL_FLAGGO  3
`define SSX_CTRL_OUTGO   4
`define SSX_CTRL_POTGO   5

// -------------------------------------------------------------------------
// output byte fields
// -------------------------------------------------------------------------
`define SSX_OB_AUX2      4
`define SSX_OB_ALARM     3
`define SSX_OB_FSTART    2
`define SSX_OB_FRUN      1
`define SSX_OB_REFSEL    0

// pot command: [2:0] address, [3] up, [11:4] step count
`define SSX_POT_ADDR_HI  2
`define SSX_POT_UP       3
`define SSX_POT_CNT_LO   4
`define SSX_POT_CNT_HI   11

// -------------------------------------------------------------------------
// peripheral address codes on the shared lines
// -------------------------------------------------------------------------
`define SSX_ADDR_FLAGS   3'h1
`define SSX_ADDR_OUTREG  3'h2
`define SSX_ADDR_IDLE    3'h0

// -------------------------------------------------------------------------
// timing
// -------------------------------------------------------------------------
`define SSX_CLK_HZ       10000000
`define SSX_FAN_START_S  10
`define SSX_FAN_CYCLES   (`SSX_FAN_START_S * `SSX_CLK_HZ)
`define SSX_HALF_BIT     8'h04
`define SSX_ALARM_HALF   24'h2625A0
`define SSX_BITS         4'h8
`define SSX_OUT_RESET    8'h06

`endif

// ### pkg/ssx_pkg.sv
// types shared by the shelf expander controller files
package ssx_pkg;

  // shared serial bus pins driven by the controller
  typedef struct packed {
    logic [2:0] addr;
    logic       sclk;
    logic       enable;
    logic       data;
  } ssx_bus_type;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_LOW,
    ST_HIGH,
    ST_LATCH_LOW,
    ST_LATCH_HIGH,
    ST_DONE
  } ssx_state_type;

  // kinds of bus operation
  typedef enum logic [1:0] {
    OP_FLAGS,
    OP_OUT,
    OP_POT
  } ssx_op_type;

  // sequencer state record
  typedef struct packed {
    ssx_state_type state;
    ssx_op_type    op;
    ssx_bus_type   bus;
    logic [7:0]    tick;
    logic [8:0]    left;
    logic [7:0]    shreg;
    logic [7:0]    flags;
    logic          busy;
    logic          done;
  } ssx_seq_type;

endpackage : ssx_pkg

// ### verilog/ssx_bus_seq.sv
// serial bus sequencer: address, enable and clock pulses on the shared bus
`timescale 1ns/1ns
`include "ssx_cfg.svh"

module ssx_bus_seq (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // command
  input  wire logic                 go,
  input  wire ssx_pkg::ssx_op_type  op,
  input  wire logic [2:0]           addr,
  input  wire logic                 pot_up,
  input  wire logic [7:0]           pot_steps,
  input  wire logic [7:0]           out_byte,
  // serial status, already synchronised
  input  wire logic                 status_in,
  // results
  output ssx_pkg::ssx_bus_type      bus,
  output logic                      busy,
  output logic                      done,
  output logic [7:0]                flags
);

  ssx_pkg::ssx_seq_type s_r;
  ssx_pkg::ssx_seq_type s_nxt;

  // -----------------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------------
  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    if (s_r.tick != 8'h00) begin
      s_nxt.tick = s_r.tick - 8'h01;
    end else begin
      unique case (s_r.state)
        ssx_pkg::ST_IDLE: begin
          if (go) begin
            s_nxt.op       = op;
            s_nxt.bus.addr = addr;      // R1
            s_nxt.bus.sclk = 1'b0;
            // flag load needs enable high, pot direction rides on enable
            s_nxt.bus.enable = (op == ssx_pkg::OP_FLAGS) ? 1'b1 :
                               (op == ssx_pkg::OP_POT) ? pot_up : 1'b0; // R2 R6
            s_nxt.shreg = out_byte;
            s_nxt.left  = (op == ssx_pkg::OP_POT) ? {1'b0, pot_steps} :
                          (op == ssx_pkg::OP_FLAGS) ? 9'h009 : 9'h008;
            s_nxt.busy  = 1'b1;
            s_nxt.tick  = `SSX_HALF_BIT;
            s_nxt.state = ssx_pkg::ST_SETUP;
          end
        end
        ssx_pkg::ST_SETUP, ssx_pkg::ST_LOW: begin
          if (s_r.left == 9'h000) begin
            s_nxt.state = (s_r.op == ssx_pkg::OP_OUT) ?
                          ssx_pkg::ST_LATCH_LOW : ssx_pkg::ST_DONE;
            s_nxt.bus.enable = (s_r.op == ssx_pkg::OP_OUT); // R11
          end else begin
            if (s_r.op == ssx_pkg::OP_OUT) begin
              s_nxt.bus.data = s_r.shreg[7];   // R12
            end
            s_nxt.state = ssx_pkg::ST_HIGH;
          end
          s_nxt.tick = `SSX_HALF_BIT;
        end
        ssx_pkg::ST_HIGH: begin
          // rising edge: device takes data or steps the pot
          s_nxt.bus.sclk = 1'b1;           // R3 R10
          s_nxt.tick     = `SSX_HALF_BIT;
          s_nxt.state    = ssx_pkg::ST_LATCH_HIGH;
        end
        ssx_pkg::ST_LATCH_HIGH: begin
          s_nxt.bus.sclk = 1'b0;
          s_nxt.tick     = `SSX_HALF_BIT;
          s_nxt.left     = s_r.left - 9'h001;
          s_nxt.shreg    = {s_r.shreg[6:0], 1'b0};
          if (s_r.op == ssx_pkg::OP_FLAGS) begin
            // after the load pulse enable drops and bits follow lsb first
            s_nxt.bus.enable = 1'b0;       // R7
            if (s_r.left != 9'h009) begin
              s_nxt.flags = {status_in, s_r.flags[7:1]}; // R8
            end
          end
          if (s_r.op == ssx_pkg::OP_OUT && s_r.bus.enable) begin
            s_nxt.state = ssx_pkg::ST_DONE;
          end else begin
            s_nxt.state = ssx_pkg::ST_LOW;
          end
        end
        ssx_pkg::ST_LATCH_LOW: begin
          s_nxt.bus.sclk = 1'b1;           // R11
          s_nxt.tick     = `SSX_HALF_BIT;
          s_nxt.state    = ssx_pkg::ST_LATCH_HIGH;
        end
        ssx_pkg::ST_DONE: begin
          s_nxt.bus.enable = 1'b0;
          s_nxt.bus.data   = 1'b0;
          s_nxt.bus.addr   = `SSX_ADDR_IDLE;
          s_nxt.busy       = 1'b0;
          s_nxt.done       = 1'b1;
          s_nxt.state      = ssx_pkg::ST_IDLE;
        end
        default: s_nxt.state = ssx_pkg::ST_IDLE;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus   = s_r.bus;
  assign busy  = s_r.busy;
  assign done  = s_r.done;
  assign flags = s_r.flags;

endmodule : ssx_bus_seq

// ### verilog/ssx_ctrl.sv
// shelf expander controller: apb registers, fan start, alarm, bus driver
//
// Notes on behaviour
// R1 - address lines are set before enable and clock move; the sequencer sets enable in the same cycle as the address.
// R2 - enable level chooses pot direction: high steps up, low down.
// R3 - each clock pulse moves the addressed pot one step.
// R4 - after reset fan run and start set; start cleared after ten seconds.
// R5 - status register holds one fault flag for each of five modules.
// R6 - flag capture: address, enable high, one low-high-low clock pulse.
// R7 - with enable low each further pulse presents the next status bit.
// R8 - lsb first; three dont-care bits, fourth amplifier flag, eighth flag zero.
// R9 - amplifier fault arrives as flag four in the serial status.
// R10 - output data bit is taken by the device on rising clock.
// R11 - after eight bits enable goes high; next pulse latches the byte.
// R12 - output byte is sent most significant bit first.
// R13 - bit 3 alarm led, bit 2 max fan, bit 1 normal fan.
// R14 - bit 0 picks internal or external receive reference.
// R15 - bit 4 high energises the second auxiliary relay.
// R16 - first auxiliary line high energises the first relay.
// R17 - stopping an auxiliary function returns its bit inactive.
// R18 - power-sense fault while keyed: unkey, flash alarm, block till reset.
// R19 - squelch source manual or digital; digital disables manual control.
// R20 - squelch relay follows receive mute from carrier detection.
// R21 - data toward the handset is inverted by the shelf.
// R22 - device decodes address lines; only selected peripheral responds.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "ssx_cfg.svh"

module ssx_ctrl #(
  parameter int unsigned FAN_CYCLES = `SSX_FAN_CYCLES
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // shared serial bus toward the shelf
  output logic [2:0]       addr_bits,
  output logic             serial_clk,
  output logic             expander_enable,
  output logic             expander_data_in,
  input  wire logic        flag_serial_out,
  // loose control lines
  output logic             aux_one_control,
  output logic             amplifier_key,
  output logic             squelch_divider_source,
  input  wire logic        reflected_power_sense
);

  // -----------------------------------------------------------------------
  // state record
  // -----------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  out_byte;
    logic        aux1;
    logic        txreq;
    logic        sqdig;
    logic [11:0] pot_cmd;
    logic        go;
    ssx_pkg::ssx_op_type op;
    logic [31:0] fan_cnt;
    logic        fan_done;
    logic        fan_go;
    logic        tx_block;
    logic [23:0] flash_cnt;
    logic        flash;
    logic        out_pending;
    logic [2:0]  sync_st;
    logic [2:0]  sync_ps;
    logic        st_val;
    logic        ps_val;
    logic        key;
  } ssx_ctrl_type;

  ssx_ctrl_type c_r;
  ssx_ctrl_type c_nxt;

  ssx_pkg::ssx_bus_type bus;
  logic                 seq_busy;
  logic                 seq_done;
  logic [7:0]           seq_flags;

  // address decode used by several fields, on writes and reads
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // -----------------------------------------------------------------------
  // bus sequencer
  // -----------------------------------------------------------------------
  ssx_bus_seq u_seq (
    .pclk      (pclk),
    .presetn   (presetn),
    .go        (c_r.go),
    .op        (c_r.op),
    .addr      ((c_r.op == ssx_pkg::OP_POT) ?
                c_r.pot_cmd[`SSX_POT_ADDR_HI:0] :
                (c_r.op == ssx_pkg::OP_FLAGS) ? `SSX_ADDR_FLAGS :
                `SSX_ADDR_OUTREG),
    .pot_up    (c_r.pot_cmd[`SSX_POT_UP]),
    .pot_steps (c_r.pot_cmd[`SSX_POT_CNT_HI:`SSX_POT_CNT_LO]),
    .out_byte  (c_r.out_byte),
    .status_in (c_r.st_val),
    .bus       (bus),
    .busy      (seq_busy),
    .done      (seq_done),
    .flags     (seq_flags)
  );

  // -----------------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------------
  always_comb begin
    c_nxt        = c_r;
    c_nxt.go     = 1'b0;
    c_nxt.pready = 1'b0;
    // three-stage pin sync; a change counts when stages two and three agree
    c_nxt.sync_st = {c_r.sync_st[1:0], flag_serial_out};
    c_nxt.sync_ps = {c_r.sync_ps[1:0], reflected_power_sense};
    if (c_r.sync_st[1] == c_r.sync_st[2]) begin
      c_nxt.st_val = c_r.sync_st[2];
    end
    if (c_r.sync_ps[1] == c_r.sync_ps[2]) begin
      c_nxt.ps_val = c_r.sync_ps[2];
    end

    // fan start: both bits high from reset, start dropped after the delay
    if (!c_r.fan_done) begin
      if (c_r.fan_cnt >= FAN_CYCLES - 1) begin
        c_nxt.fan_done = 1'b1;
        c_nxt.out_byte[`SSX_OB_FSTART] = 1'b0;        // R4
        c_nxt.out_pending = 1'b1;
      end else begin
        c_nxt.fan_cnt = c_r.fan_cnt + 32'h1;
      end
    end
    if (!c_r.fan_go) begin
      c_nxt.fan_go      = 1'b1;
      c_nxt.out_pending = 1'b1;                       // R4
    end

    // power-sense fault while keyed latches a transmit block
    if (c_r.key && c_r.ps_val) begin
      c_nxt.tx_block = 1'b1;                          // R18
    end
    c_nxt.key = c_r.txreq && !c_nxt.tx_block;         // R18
    if (c_r.tx_block) begin
      if (c_r.flash_cnt == 24'h0) begin
        c_nxt.flash_cnt = `SSX_ALARM_HALF;
        c_nxt.flash     = !c_r.flash;
        c_nxt.out_byte[`SSX_OB_ALARM] = !c_r.flash;   // R18
        c_nxt.out_pending = 1'b1;
      end else begin
        c_nxt.flash_cnt = c_r.flash_cnt - 24'h1;
      end
    end

    // apb: no wait state, answer on the cycle after setup
    if (psel && !penable) begin
      c_nxt.pready  = 1'b1;
      c_nxt.pslverr = 1'b0;
      c_nxt.prdata  = 32'h0;
      if (pwrite) begin
        if (hit(paddr, `SSX_OFS_CTRL)) begin
          c_nxt.aux1  = pwdata[`SSX_CTRL_AUX1];        // R16 R17
          c_nxt.txreq = pwdata[`SSX_CTRL_TXREQ];
          c_nxt.sqdig = pwdata[`SSX_CTRL_SQDIG];       // R19
          if (pwdata[`SSX_CTRL_FLAGGO] && !seq_busy) begin
            c_nxt.go = 1'b1;
            c_nxt.op = ssx_pkg::OP_FLAGS;
          end else if (pwdata[`SSX_CTRL_OUTGO] && !seq_busy) begin
            c_nxt.out_pending = 1'b1;
          end else if (pwdata[`SSX_CTRL_POTGO] && !seq_busy) begin
            c_nxt.go = 1'b1;
            c_nxt.op = ssx_pkg::OP_POT;
          end
        end else if (hit(paddr, `SSX_OFS_OUTBYTE)) begin
          c_nxt.out_byte = pwdata[7:0];               // R13 R14 R15 R17
        end else if (hit(paddr, `SSX_OFS_POT)) begin
          c_nxt.pot_cmd = pwdata[11:0];
        end else if (!hit(paddr, `SSX_OFS_STATUS) &&
                     !hit(paddr, `SSX_OFS_FLAGS)) begin
          c_nxt.pslverr = 1'b1;
        end
      end else begin
        if (hit(paddr, `SSX_OFS_CTRL)) begin
          c_nxt.prdata = {29'h0, c_r.sqdig, c_r.txreq, c_r.aux1};
        end else if (hit(paddr, `SSX_OFS_OUTBYTE)) begin
          c_nxt.prdata = {24'h0, c_r.out_byte};
        end else if (hit(paddr, `SSX_OFS_POT)) begin
          c_nxt.prdata = {20'h0, c_r.pot_cmd};
        end else if (hit(paddr, `SSX_OFS_STATUS)) begin
          c_nxt.prdata = {27'h0, c_r.out_pending, c_r.fan_done,
                          c_r.tx_block, c_r.key, seq_busy | c_r.go};
        end else if (hit(paddr, `SSX_OFS_FLAGS)) begin
          // amplifier flag is fourth out, so it lands in bit three
          c_nxt.prdata = {24'h0, seq_flags};          // R5 R9
        end else begin
          c_nxt.pslverr = 1'b1;
        end
      end
    end

    // pending output-register refresh starts when the bus is free
    if (c_r.out_pending && !seq_busy && !c_r.go && !c_nxt.go) begin
      c_nxt.go          = 1'b1;
      c_nxt.op          = ssx_pkg::OP_OUT;
      c_nxt.out_pending = 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // state register; reset output byte has fan run and start both high
  // -----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_r          <= '0;
      c_r.out_byte <= `SSX_OUT_RESET;                  // R4
    end else begin
      c_r <= c_nxt;
    end
  end

  // -----------------------------------------------------------------------
  // outputs, all flip-flop driven
  // -----------------------------------------------------------------------
  assign prdata                 = c_r.prdata;
  assign pready                 = c_r.pready;
  assign pslverr                = c_r.pslverr;
  assign addr_bits              = bus.addr;
  assign serial_clk             = bus.sclk;
  assign expander_enable        = bus.enable;
  assign expander_data_in       = bus.data;
  assign aux_one_control        = c_r.aux1;
  assign amplifier_key          = c_r.key;
  assign squelch_divider_source = c_r.sqdig;

  // seq_done is only a pulse for observers of the sequencer
  logic unused_done;
  assign unused_done = seq_done;

endmodule : ssx_ctrl

// ### verif/ssx_dev_model.sv
// behavioural model of the shelf side: flag, output and pot devices
`timescale 1ns/1ns
`include "ssx_cfg.svh"

module ssx_dev_model (
  // shared serial bus
  input  wire logic [2:0] addr_bits,
  input  wire logic       serial_clk,
  input  wire logic       expander_enable,
  input  wire logic       expander_data_in,
  output logic            flag_serial_out,
  // module fault flags, bit 4 amplifier
  input  wire logic [4:0] fault_flags,
  input  wire logic       aux_one_control,
  // device state seen by the bench
  output logic [7:0]      out_q,
  output logic [7:0][7:0] wiper,
  output logic            relay_one,
  output logic            relay_two
);
  logic [7:0] flag_sr = 8'h00;
  logic [7:0] out_buf = 8'h00;
  logic       flag_q  = 1'b0;

  // power-up state, pots at mid-scale
  initial begin
    out_q = 8'h00;
    wiper = {8{8'h80}};
  end

  // -------------------------------------------------------------------
  // only the addressed part reacts to the shared clock
  // -------------------------------------------------------------------
  always @(posedge serial_clk) begin
    if (addr_bits == `SSX_ADDR_FLAGS) begin
      // three dont-care bits go out first, flag zero last
      if (expander_enable)
        flag_sr <= {fault_flags[0], fault_flags[1], fault_flags[2],
                    fault_flags[3], fault_flags[4], 3'b101};
      else begin
        flag_q  <= flag_sr[0];
        flag_sr <= {1'b0, flag_sr[7:1]};
      end
    end else if (addr_bits == `SSX_ADDR_OUTREG) begin
      if (expander_enable)
        out_q <= out_buf;
      else
        out_buf <= {out_buf[6:0], expander_data_in};
    end else if (addr_bits != `SSX_ADDR_IDLE) begin
      wiper[addr_bits] <= wiper[addr_bits]
                          + (expander_enable ? 8'h01 : 8'hFF);
    end
  end

  // unselected status line shows the inverse of the last bit shifted out
  assign flag_serial_out = (addr_bits == `SSX_ADDR_FLAGS) ? flag_q : ~flag_q;
  assign relay_one       = aux_one_control;
  assign relay_two       = out_q[`SSX_OB_AUX2];

endmodule : ssx_dev_model

// ### verif/ssx_ctrl_chk.sv
// port assertions for the shelf expander controller
`timescale 1ns/1ns
`include "ssx_cfg.svh"

module ssx_ctrl_chk #(
  parameter int unsigned FAN_CYCLES = `SSX_FAN_CYCLES
) (
  // apb side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // shared serial bus
  input wire logic [2:0]  addr_bits,
  input wire logic        serial_clk,
  input wire logic        expander_enable,
  input wire logic        expander_data_in,
  // loose lines
  input wire logic        aux_one_control,
  input wire logic        amplifier_key,
  input wire logic        reflected_power_sense
);
  logic aux_want_r;
  logic wr_ctrl;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // -------------------------------------------------------------------
  // last aux level that software asked for
  // -------------------------------------------------------------------
  assign wr_ctrl = psel && penable && pready && pwrite
                   && paddr == `SSX_OFS_CTRL;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      aux_want_r <= 1'b0;
    else if (wr_ctrl)
      aux_want_r <= pwdata[`SSX_CTRL_AUX1];
  end

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  property p_ready_next;
    psel && !penable |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("no ready");

  property p_addr_first;
    $rose(serial_clk) |-> addr_bits != `SSX_ADDR_IDLE
                          && $past(addr_bits, 4) == addr_bits;
  endproperty
  a_addr_first: assert property (p_addr_first) else $error("addr late");

  property p_stable_edge;
    $rose(serial_clk) |-> $stable(expander_enable)
                          && $stable(expander_data_in);
  endproperty
  a_stable_edge: assert property (p_stable_edge) else $error("moved");

  property p_sclk_high;
    $rose(serial_clk) |=> serial_clk [*4] ##1 !serial_clk;
  endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("bad pulse");

  property p_load_then_low;
    addr_bits == `SSX_ADDR_FLAGS && $past(expander_enable)
      && $fell(serial_clk) |-> !expander_enable;
  endproperty
  a_load_then_low: assert property (p_load_then_low) else $error("en");

  property p_latch_end;
    addr_bits == `SSX_ADDR_OUTREG && expander_enable && $fell(serial_clk)
      |-> ##[0:6] addr_bits == `SSX_ADDR_IDLE;
  endproperty
  a_latch_end: assert property (p_latch_end) else $error("latch");

  property p_aux_follow;
    aux_want_r != aux_one_control |=> aux_want_r == aux_one_control;
  endproperty
  a_aux_follow: assert property (p_aux_follow) else $error("aux");

  property p_unkey;
    reflected_power_sense [*5] ##0 amplifier_key |-> ##[0:4] !amplifier_key;
  endproperty
  a_unkey: assert property (p_unkey) else $error("still keyed");

endmodule : ssx_ctrl_chk

bind ssx_ctrl ssx_ctrl_chk #(.FAN_CYCLES(FAN_CYCLES)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .addr_bits(addr_bits), .serial_clk(serial_clk),
  .expander_enable(expander_enable), .expander_data_in(expander_data_in),
  .aux_one_control(aux_one_control), .amplifier_key(amplifier_key),
  .reflected_power_sense(reflected_power_sense));

// ### verif/test_ssx_ctrl.sv
// self-checking bench for the shelf expander controller
`timescale 1ns/1ns
`include "ssx_cfg.svh"

module test_ssx_ctrl;
  localparam int unsigned FAN = 2000;
  logic            pclk = 1'b0, presetn = 1'b0, sense = 1'b0;
  logic            psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]      paddr = 8'h00;
  logic [31:0]     pwdata = 32'h0, prdata, rd, keep;
  logic            pready, pslverr, err, aux, key, sq, flag_in;
  logic [2:0]      addr_bits;
  logic            sclk, enable, data_out, relay1, relay2;
  logic [4:0]      faults = 5'h00;
  logic [7:0]      out_q, exp8;
  logic [7:0][7:0] wiper;
  logic [7:0]      obytes [3] = '{8'h1A, 8'h0B, 8'h02};
  logic [4:0]      fsets [3]  = '{5'h10, 5'h01, 5'h0E};
  logic [31:0]     levels [3] = '{32'h1, 32'h5, 32'h0};
  int              error_cnt = 0, n_compared = 0;

  ssx_ctrl #(.FAN_CYCLES(FAN)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .addr_bits(addr_bits),
    .serial_clk(sclk), .expander_enable(enable),
    .expander_data_in(data_out), .flag_serial_out(flag_in),
    .aux_one_control(aux), .amplifier_key(key),
    .squelch_divider_source(sq), .reflected_power_sense(sense));

  ssx_dev_model i_dev (
    .addr_bits(addr_bits), .serial_clk(sclk), .expander_enable(enable),
    .expander_data_in(data_out), .flag_serial_out(flag_in),
    .fault_flags(faults), .aux_one_control(aux), .out_q(out_q),
    .wiper(wiper), .relay_one(relay1), .relay_two(relay2));

  always #50 pclk = ~pclk;

  // -------------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------------
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one apb transfer; request held until ready is sampled high
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : xfer

  // poll busy; commands are ignored while the sequencer runs
  task automatic wait_idle();
    for (int i = 0; i < 400; i++) begin
      xfer(`SSX_OFS_STATUS, 1'b0, 32'h0);
      if (rd[0] === 1'b0 && rd[4] === 1'b0) return;
    end
    error_cnt++;
  endtask : wait_idle

  task automatic cmd(input int b);
    wait_idle();
    xfer(`SSX_OFS_CTRL, 1'b1, keep | (32'h1 << b));
    wait_idle();
  endtask : cmd

  // -------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------
  initial begin
    keep = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    wait_idle();
    chk("fan start byte", 32'h06, {24'h0, out_q});
    xfer(8'h14, 1'b0, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    // fan start time is shortened by the parameter
    for (int i = 0; i < 1000; i++) begin
      xfer(`SSX_OFS_STATUS, 1'b0, 32'h0);
      if (rd[3] === 1'b1) break;
    end
    wait_idle();
    chk("fan run byte", 32'h02, {24'h0, out_q});
    // output bytes: aux two, alarm, normal fan, reference select
    foreach (obytes[i]) begin
      xfer(`SSX_OFS_OUTBYTE, 1'b1, {24'h0, obytes[i]});
      cmd(`SSX_CTRL_OUTGO);
      chk("out byte", {24'h0, obytes[i]}, {24'h0, out_q});
      chk("aux two", {31'h0, obytes[i][4]}, {31'h0, relay2});
    end
    // flag reads: amplifier alone, flag zero alone, a mix
    foreach (fsets[i]) begin
      faults <= fsets[i];
      cmd(`SSX_CTRL_FLAGGO);
      xfer(`SSX_OFS_FLAGS, 1'b0, 32'h0);
      exp8 = {fsets[i][0], fsets[i][1], fsets[i][2], fsets[i][3],
              fsets[i][4], 3'b000};
      chk("flags", {24'h0, exp8}, {24'h0, rd[7:3], 3'b000});
    end
    // pots: five up on address 3, two down on address 5
    xfer(`SSX_OFS_POT, 1'b1, 32'h5B);
    cmd(`SSX_CTRL_POTGO);
    xfer(`SSX_OFS_POT, 1'b1, 32'h25);
    cmd(`SSX_CTRL_POTGO);
    chk("pot three", 32'h85, {24'h0, wiper[3]});
    chk("pot five", 32'h7E, {24'h0, wiper[5]});
    chk("pot four", 32'h80, {24'h0, wiper[4]});
    // aux one and squelch source levels
    foreach (levels[i]) begin
      keep = levels[i];
      xfer(`SSX_OFS_CTRL, 1'b1, keep);
      xfer(`SSX_OFS_STATUS, 1'b0, 32'h0);
      chk("aux one", {31'h0, keep[0]}, {31'h0, relay1});
      chk("squelch src", {31'h0, keep[2]}, {31'h0, sq});
    end
    // power-sense fault while keyed, then a retry
    keep = 32'h2;
    xfer(`SSX_OFS_CTRL, 1'b1, keep);
    xfer(`SSX_OFS_STATUS, 1'b0, 32'h0);
    chk("keyed", 32'h1, {31'h0, rd[1]});
    sense <= 1'b1;
    repeat (10) @(posedge pclk);
    chk("unkeyed", 32'h0, {31'h0, key});
    sense <= 1'b0;
    xfer(`SSX_OFS_CTRL, 1'b1, 32'h0);
    xfer(`SSX_OFS_CTRL, 1'b1, keep);
    xfer(`SSX_OFS_STATUS, 1'b0, 32'h0);
    chk("tx blocked", 32'h1, {31'h0, rd[2]});
    chk("still unkeyed", 32'h0, {31'h0, key});
    wait_idle();
    chk("alarm on", 32'h1, {31'h0, out_q[3]});
    end_of_test();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    end_of_test();
  end

endmodule : test_ssx_ctrl
